// ==== core/qsp_mem.sv ====
// byte-lane writable storage array with registered read data
`timescale 1ns/1ps
module qsp_mem #(
	parameter int AW     = 6,
	parameter int LANES  = 4,
	parameter int LANE_W = 9
) (
	// clock
	input  wire logic                      clock,
	// write side
	input  wire logic                      wrEn,
	input  wire logic [AW-1:0]             wrAddr,
	input  wire logic [LANES-1:0]          wrLane,
	input  wire logic [LANES*LANE_W-1:0]   wrData,
	// read side
	input  wire logic [AW-1:0]             rdAddr,
	output logic      [LANES*LANE_W-1:0]   rdData
);
	logic [LANES*LANE_W-1:0] store [0:(1<<AW)-1];

	always_ff @(posedge clock) begin
		for (int i = 0; i < LANES; i++) begin
			if (wrEn && wrLane[i]) begin
				store[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
			end
		end
	end

	always_ff @(posedge clock) begin
		rdData <= store[rdAddr];
	end
endmodule

// ==== core/qsp_pkg.sv ====
// constants and types shared by the burst sram port logic
package qsp_pkg;
	localparam int DATA_W      = 36;
	localparam int ADDR_W      = 20;
	localparam int LANES       = 4;
	localparam int LANE_W      = 9;
	localparam int BURST_LEN   = 4;
	localparam int BEAT_W      = 2;
	localparam int SYNC_STAGES = 2;
	// termination range codes after power-up latch
	localparam logic TERM_LOW   = 1'b0;
	localparam logic TERM_HIGH  = 1'b1;
	localparam logic TERM_RESET = 1'b1;
	// cycles after reset release at which the range select is captured
	localparam int     TERM_LATCH_DELAY = 4;
	localparam logic [2:0] TERM_CNT_RESET = 3'h0;
	typedef enum logic [1:0] {
		QSP_RD_IDLE  = 2'b00,
		QSP_RD_BURST = 2'b01,
		QSP_RD_TAIL  = 2'b10
	} qsp_rd_state_e;
endpackage

// ==== core/qsp_port.sv ====
// separate-io double-rate burst sram port: input sampling, write and read bursts
`timescale 1ns/1ps
// Overview of operation
// [R01] write data sampled on both strobe edges
// [R02] low write select at true edge starts write
// [R03] high write select ignores write data
// [R04] lane select high keeps old byte
// [R05] lane n covers nine data bits each
// [R06] lane selects sampled with their beat
// [R07] one address bus, ignored when deselected
// [R08] address 21 or 20 bits, four arrays
// [R09] read data driven on both strobe edges
// [R10] low read select at true edge starts read
// [R11] deselect finishes burst then outputs float
// [R12] each read is four sequential beats
// [R13] valid flag marks data, aligned with echo; here the flag trails the echo edge by two cycles
// [R14] termination range latched at power-up
// [R15] floating range select means high range
// [R16] accesses launch on true strobe rise
// [R17] echo strobes run free, follow input strobe
// [R18] write carries four beats with lanes
module qsp_port #(
	parameter int DATA_W = qsp_pkg::DATA_W,
	parameter int ADDR_W = qsp_pkg::ADDR_W,
	parameter int MEM_AW = 6
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// input strobe pair from the controller
	input  wire logic              inStrobe,
	input  wire logic              inStrobeN,
	// port selects and address
	input  wire logic              write_port_sel_n,
	input  wire logic              read_port_sel_n,
	input  wire logic [ADDR_W-1:0] addr,
	// write data and lanes
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic [qsp_pkg::LANES-1:0] byte_lane_sel_n,
	// read data and echo
	output logic      [DATA_W-1:0] rdData,
	output logic                   rdDataOe,
	output logic                   echo_strobe,
	output logic                   echo_strobeN,
	output logic                   read_valid_flag,
	input  wire logic              rdReady,
	// termination
	input  wire logic              termination_range_sel,
	input  wire logic              termRangeSelDriven,
	output logic                   termRangeHigh
);
	localparam int LW = qsp_pkg::LANE_W;
	localparam int NL = DATA_W / LW;

	function automatic logic [MEM_AW-1:0] beatAddr(input logic [ADDR_W-1:0] base,
		input logic [qsp_pkg::BEAT_W-1:0] beat);
		logic [ADDR_W+qsp_pkg::BEAT_W-1:0] full;
		full     = {base, beat};
		beatAddr = full[MEM_AW-1:0];
	endfunction

	// two-flop synchronisers on every pin-level input
	logic [1:0]          kS1_q, kS2_q, kPrev_q;
	logic                wpsS1_q, wpsS2_q, rpsS1_q, rpsS2_q;
	logic [ADDR_W-1:0]   addrS1_q, addrS2_q;
	logic [DATA_W-1:0]   datS1_q, datS2_q;
	logic [NL-1:0]       lanS1_q, lanS2_q;
	logic                odtS1_q, odtS2_q, drvS1_q, drvS2_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			// idle levels of the pair (true low, complement high) so no false edge follows reset
			kS1_q    <= 2'h2;
			kS2_q    <= 2'h2;
			kPrev_q  <= 2'h2;
			wpsS1_q  <= 1'b1;
			wpsS2_q  <= 1'b1;
			rpsS1_q  <= 1'b1;
			rpsS2_q  <= 1'b1;
			addrS1_q <= '0;
			addrS2_q <= '0;
			datS1_q  <= '0;
			datS2_q  <= '0;
			lanS1_q  <= '1;
			lanS2_q  <= '1;
			odtS1_q  <= qsp_pkg::TERM_RESET;
			odtS2_q  <= qsp_pkg::TERM_RESET;
			drvS1_q  <= 1'b0;
			drvS2_q  <= 1'b0;
		end else begin
			kS1_q    <= {inStrobeN, inStrobe};
			kS2_q    <= kS1_q;
			kPrev_q  <= kS2_q;
			wpsS1_q  <= write_port_sel_n;
			wpsS2_q  <= wpsS1_q;
			rpsS1_q  <= read_port_sel_n;
			rpsS2_q  <= rpsS1_q;
			addrS1_q <= addr;
			addrS2_q <= addrS1_q;
			datS1_q  <= wrData;
			datS2_q  <= datS1_q;
			lanS1_q  <= byte_lane_sel_n[NL-1:0];
			lanS2_q  <= lanS1_q;
			odtS1_q  <= termination_range_sel;
			odtS2_q  <= odtS1_q;
			drvS1_q  <= termRangeSelDriven;
			drvS2_q  <= drvS1_q;
		end
	end

	// edges of the true and complementary strobes
	wire kRise   = kS2_q[0] && !kPrev_q[0]; // [R16]
	wire kbRise  = kS2_q[1] && !kPrev_q[1];
	wire anyRise = kRise || kbRise;

	// write engine: four beats on alternating strobe edges
	logic                        wrAct_q;
	logic [qsp_pkg::BEAT_W-1:0]  wrBeat_q;
	logic [ADDR_W-1:0]           wrBase_q;
	wire  wrStart  = kRise && !wpsS2_q && !wrAct_q;           // [R02]
	wire  wrBeatEn = wrAct_q && anyRise;                       // [R01] [R03]
	wire  wrLast   = wrBeatEn && (wrBeat_q == 2'(qsp_pkg::BURST_LEN - 1));
	wire  [qsp_pkg::LANES-1:0] wrLaneEn;

	// lane n enables bits n*9 up to n*9+8; narrow parts only have lanes 0 and 1
	generate
		for (genvar g = 0; g < qsp_pkg::LANES; g++) begin : gLane
			if (g < NL) begin : gUsed
				assign wrLaneEn[g] = !lanS2_q[g]; // [R04] [R05] [R06]
			end else begin : gNone
				assign wrLaneEn[g] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrAct_q  <= 1'b0;
			wrBeat_q <= '0;
			wrBase_q <= '0;
		end else if (wrStart) begin
			wrAct_q  <= 1'b1; // [R18]
			wrBeat_q <= '0;
			wrBase_q <= addrS2_q; // [R07]
		end else if (wrBeatEn) begin
			wrAct_q  <= !wrLast;
			wrBeat_q <= wrBeat_q + 2'd1;
		end
	end

	// the first beat rides the same rising edge that launches the burst
	wire  wrEnMem   = wrStart || wrBeatEn;
	wire  [ADDR_W-1:0] wrBaseNow = wrStart ? addrS2_q : wrBase_q;
	wire  [qsp_pkg::BEAT_W-1:0] wrBeatNow = wrStart ? 2'd0 : wrBeat_q;
	wire  [qsp_pkg::LANES*LW-1:0] memWrData;
	assign memWrData = (qsp_pkg::LANES*LW)'(datS2_q);

	// read engine
	qsp_pkg::qsp_rd_state_e rdSt_q;
	logic [qsp_pkg::BEAT_W-1:0] rdBeat_q;
	logic [ADDR_W-1:0]          rdBase_q;
	logic                       fetchV_q;
	wire  rdStart  = kRise && !rpsS2_q && (rdSt_q != qsp_pkg::QSP_RD_BURST); // [R10] [R07]
	wire  skIn;
	wire  rdStep   = (rdSt_q == qsp_pkg::QSP_RD_BURST) && anyRise && skIn; // [R09]
	wire  rdLast   = rdStep && (rdBeat_q == 2'(qsp_pkg::BURST_LEN - 1));    // [R12]
	wire  [MEM_AW-1:0] rdAddrMem = beatAddr(rdBase_q, rdBeat_q);
	wire  [qsp_pkg::LANES*LW-1:0] memRdData;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdSt_q   <= qsp_pkg::QSP_RD_IDLE;
			rdBeat_q <= '0;
			rdBase_q <= '0;
			fetchV_q <= 1'b0;
		end else begin
			fetchV_q <= rdStep;
			case (rdSt_q)
				qsp_pkg::QSP_RD_IDLE, qsp_pkg::QSP_RD_TAIL: begin
					if (rdStart) begin
						rdSt_q   <= qsp_pkg::QSP_RD_BURST;
						rdBeat_q <= '0;
						rdBase_q <= addrS2_q;
					end else if (kRise) begin
						rdSt_q <= qsp_pkg::QSP_RD_IDLE; // [R11]
					end
				end
				qsp_pkg::QSP_RD_BURST: begin
					if (rdStep) begin
						rdBeat_q <= rdBeat_q + 2'd1;
					end
					if (rdLast) begin
						rdSt_q <= qsp_pkg::QSP_RD_TAIL; // [R11]
					end
				end
				default: rdSt_q <= qsp_pkg::QSP_RD_IDLE;
			endcase
		end
	end

	qsp_mem #(
		.AW     (MEM_AW),
		.LANES  (qsp_pkg::LANES),
		.LANE_W (LW)
	) uMem (
		.clock  (clock),
		.wrEn   (wrEnMem),
		.wrAddr (beatAddr(wrBaseNow, wrBeatNow)), // [R08]
		.wrLane (wrLaneEn),
		.wrData (memWrData),
		.rdAddr (rdAddrMem),
		.rdData (memRdData)
	);

	// fetched words pass a two-entry buffer so a stalled receiver loses none
	wire               skReady;
	wire               skValid;
	wire [DATA_W-1:0]  skData;
	assign skIn = skReady;

	qsp_skid #(
		.W (DATA_W)
	) uBuf (
		.clock    (clock),
		.rst      (rst),
		.inValid  (fetchV_q),
		.inReady  (skReady),
		.inData   (memRdData[DATA_W-1:0]),
		.outValid (skValid),
		.outReady (rdReady),
		.outData  (skData)
	);

	// output stage: data, flag and enable are registered with the echo pair; a beat's flag lands two cycles after its echo edge
	logic [DATA_W-1:0] rdData_q;
	logic              valid_q;
	logic              oe_q;
	logic              echo_q;
	wire  oeKeep = (rdSt_q != qsp_pkg::QSP_RD_IDLE) || skValid;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdData_q <= '0;
			valid_q  <= 1'b0;
			oe_q     <= 1'b0;
			echo_q   <= 1'b0;
		end else begin
			echo_q   <= kS2_q[0]; // [R17]
			valid_q  <= skValid && rdReady; // [R13]
			rdData_q <= (skValid && rdReady) ? skData : rdData_q;
			oe_q     <= oeKeep; // [R11]
		end
	end

	assign rdData          = rdData_q;
	assign read_valid_flag = valid_q;
	assign rdDataOe        = oe_q;
	assign echo_strobe     = echo_q;
	assign echo_strobeN    = !echo_q;

	// termination range captured once, a few cycles after reset release
	logic [2:0] termCnt_q;
	logic       termRange_q;
	wire  termLatch = (termCnt_q == 3'(qsp_pkg::TERM_LATCH_DELAY));
	wire  termPick  = drvS2_q ? odtS2_q : qsp_pkg::TERM_HIGH; // [R15]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			termCnt_q   <= qsp_pkg::TERM_CNT_RESET;
			termRange_q <= qsp_pkg::TERM_RESET;
		end else if (termCnt_q <= 3'(qsp_pkg::TERM_LATCH_DELAY)) begin
			termCnt_q <= termCnt_q + 3'd1;
			if (termLatch) begin
				termRange_q <= termPick; // [R14]
			end
		end
	end

	assign termRangeHigh = termRange_q;
endmodule

// ==== core/qsp_skid.sv ====
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module qsp_skid #(
	parameter int W = 36
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// fill side
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	// drain side
	output logic              outValid,
	input  wire logic         outReady,
	output logic      [W-1:0] outData
);
	logic [W-1:0] ent0_q;
	logic [W-1:0] ent1_q;
	logic [1:0]   cnt_q;
	wire          push = inValid && inReady;
	wire          pop  = outValid && outReady;

	assign inReady  = (cnt_q != 2'd2);
	assign outValid = (cnt_q != 2'd0);
	assign outData  = ent0_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q  <= 2'd0;
			ent0_q <= '0;
			ent1_q <= '0;
		end else begin
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
			if (pop) begin
				ent0_q <= (cnt_q == 2'd2) ? ent1_q : inData;
			end else if (push && cnt_q == 2'd0) begin
				ent0_q <= inData;
			end
			if (push && ((cnt_q == 2'd1 && !pop) || (cnt_q == 2'd2))) begin
				ent1_q <= inData;
			end
		end
	end
endmodule

// ==== sim/qsp_ctrl_model.sv ====
// memory controller model: strobe pair, selects, address and write beats
`timescale 1ns/1ps
module qsp_ctrl_model (
	// strobe pair
	output logic        inStrobe,
	output logic        inStrobeN,
	// selects and address
	output logic        write_port_sel_n,
	output logic        read_port_sel_n,
	output logic [19:0] addr,
	// write beats
	output logic [35:0] wrData,
	output logic [3:0]  byte_lane_sel_n
);
	assign inStrobeN = ~inStrobe;
	initial begin
		inStrobe = 1'b0;
		write_port_sel_n = 1'b1;
		read_port_sel_n = 1'b1;
		addr = 20'h00000;
		wrData = 36'h000000000;
		byte_lane_sel_n = 4'hf;
	end
	// strobe stands still between bursts; released lines toggle so stale values never look valid
	task automatic burst(input logic wr, input logic [19:0] a, input logic [35:0] d, input logic [15:0] ln);
		write_port_sel_n = !wr;
		read_port_sel_n = wr;
		addr = a;
		wrData = d;
		byte_lane_sel_n = ln[3:0];
		#22.5 inStrobe = 1'b1;
		for (int b = 0; b < 7; b++) begin
			#40;
			write_port_sel_n = 1'b1;
			read_port_sel_n = 1'b1;
			addr = ~addr;
			wrData = (wr && b < 4) ? d + 36'(b) : ~wrData;
			byte_lane_sel_n = (wr && b < 4) ? ln[4*b+:4] : ~byte_lane_sel_n;
			#22.5 inStrobe = ~inStrobe;
		end
	endtask
endmodule

// ==== sim/qsp_port_chk.sv ====
// assertion checker for the burst sram port
`timescale 1ns/1ps
module qsp_port_chk #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 20,
	parameter int MEM_AW = 6
) (
	// clock and reset
	input wire logic                       clock,
	input wire logic                       rst,
	// controller side
	input wire logic                       inStrobe,
	input wire logic                       inStrobeN,
	input wire logic                       write_port_sel_n,
	input wire logic                       read_port_sel_n,
	input wire logic [ADDR_W-1:0]          addr,
	input wire logic [DATA_W-1:0]          wrData,
	input wire logic [qsp_pkg::LANES-1:0]  byte_lane_sel_n,
	// read side
	input wire logic [DATA_W-1:0]          rdData,
	input wire logic                       rdDataOe,
	input wire logic                       echo_strobe,
	input wire logic                       echo_strobeN,
	input wire logic                       read_valid_flag,
	input wire logic                       rdReady,
	// termination
	input wire logic                       termination_range_sel,
	input wire logic                       termRangeSelDriven,
	input wire logic                       termRangeHigh
);
	logic [3:0] rstCnt_q;
	logic [7:0] idleCnt_q;
	// saturating counts: cycles since reset release, cycles since the last read select
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rstCnt_q  <= 4'h0;
			idleCnt_q <= 8'h00;
		end else begin
			rstCnt_q  <= rstCnt_q + {3'h0, rstCnt_q != 4'hf};
			idleCnt_q <= !read_port_sel_n ? 8'h00 : idleCnt_q + {7'h00, idleCnt_q != 8'hff};
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_echo_pair: assert property (echo_strobeN == !echo_strobe) else $error("echo pair not complementary");
	chk_echo_tracks: assert property (($stable(inStrobe) && rstCnt_q == 4'hf) [*5] |-> echo_strobe == inStrobe)
		else $error("echo strobe lost the input strobe");
	chk_valid_driven: assert property (read_valid_flag |-> rdDataOe) else $error("valid without driven bus");
	chk_data_holds: assert property (!read_valid_flag |-> $stable(rdData)) else $error("read data moved without valid");
	chk_oe_leads: assert property ($rose(read_valid_flag) |-> $past(rdDataOe)) else $error("bus not driven before beat");
	chk_idle_float: assert property (idleCnt_q == 8'hff |-> !rdDataOe) else $error("bus driven long after deselect");
	chk_idle_quiet: assert property (idleCnt_q == 8'hff |-> !read_valid_flag) else $error("valid with no read");
	chk_term_latch: assert property (rstCnt_q == 4'h7 |-> termRangeHigh == (!termRangeSelDriven || termination_range_sel))
		else $error("termination range wrong after latch");
	chk_term_hold: assert property (rstCnt_q == 4'hf |-> $stable(termRangeHigh)) else $error("termination range moved");
	cov_beat: cover property (read_valid_flag);
	cov_drive: cover property ($rose(rdDataOe));
	cov_low: cover property (rstCnt_q == 4'hf && !termRangeHigh);
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module testbench;
	typedef struct { logic [19:0] a; logic [35:0] d; logic [35:0] e; } qsp_row_s;
	logic        clock, rst, rdReady, termSel, termDriven;
	logic        inStrobe, inStrobeN, write_port_sel_n, read_port_sel_n;
	logic        rdDataOe, echo_strobe, echo_strobeN, read_valid_flag, termRangeHigh;
	logic [19:0] addr;
	logic [35:0] wrData, rdData, m;
	logic [3:0]  byte_lane_sel_n;
	logic [35:0] got[$];
	logic [35:0] expBeat[4];
	int          mismatches, checksDone;
	qsp_row_s    rows[3] = '{'{20'h00000, 36'h123456789, 36'h123456789},
		'{20'h00005, 36'hfedcba987, 36'hfedcba987}, '{20'hfff0f, 36'h5a5a5a5a5, 36'h5a5a5a5a5}};
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	qsp_port u_qsp_port (.clock(clock), .rst(rst), .inStrobe(inStrobe), .inStrobeN(inStrobeN),
		.write_port_sel_n(write_port_sel_n), .read_port_sel_n(read_port_sel_n), .addr(addr), .wrData(wrData),
		.byte_lane_sel_n(byte_lane_sel_n), .rdData(rdData), .rdDataOe(rdDataOe), .echo_strobe(echo_strobe),
		.echo_strobeN(echo_strobeN), .read_valid_flag(read_valid_flag), .rdReady(rdReady),
		.termination_range_sel(termSel), .termRangeSelDriven(termDriven), .termRangeHigh(termRangeHigh));
	qsp_ctrl_model u_qsp_ctrl_model (.inStrobe(inStrobe), .inStrobeN(inStrobeN),
		.write_port_sel_n(write_port_sel_n), .read_port_sel_n(read_port_sel_n), .addr(addr),
		.wrData(wrData), .byte_lane_sel_n(byte_lane_sel_n));
	always @(negedge clock) if (read_valid_flag === 1'b1) got.push_back(rdData);
	task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		checksDone++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (mismatches == 0 && checksDone > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (16) @(negedge clock);
		check("rstOut", {rdDataOe, read_valid_flag, echo_strobeN, termRangeHigh}, 36'h3);
		rst = 1'b0;
		repeat (10) @(negedge clock);
	endtask
	// bounded wait: a lost beat shows up as a short count, not a hang
	task automatic read_burst(input logic [19:0] a);
		int n;
		got.delete();
		u_qsp_ctrl_model.burst(1'b0, a, 36'h000000000, 16'hffff);
		n = 0;
		while (got.size() < 4 && n < 300) begin
			@(negedge clock);
			n++;
		end
		check("beats", 36'(got.size()), 36'h4);
		for (int i = 0; i < got.size() && i < 4; i++) check("rdData", got[i], expBeat[i]);
	endtask
	initial begin
		rdReady = 1'b1;
		termSel = 1'b0;
		termDriven = 1'b1;
		mismatches = 0;
		checksDone = 0;
		do_reset();
		check("termLow", termRangeHigh, 36'h0);
		foreach (rows[i]) u_qsp_ctrl_model.burst(1'b1, rows[i].a, rows[i].d, 16'h0000);
		foreach (rows[i]) begin
			for (int b = 0; b < 4; b++) expBeat[b] = rows[i].e + 36'(b);
			read_burst(rows[i].a);
		end
		// beat b leaves lane b out
		u_qsp_ctrl_model.burst(1'b1, 20'h00000, 36'h0aaaaaaaa, {4'h8, 4'h4, 4'h2, 4'h1});
		for (int b = 0; b < 4; b++) begin
			m = 36'h1ff << (9 * b);
			expBeat[b] = ((36'h0aaaaaaaa + 36'(b)) & ~m) | ((rows[0].d + 36'(b)) & m);
		end
		read_burst(20'h00000);
		for (int b = 0; b < 4; b++) expBeat[b] = rows[1].e + 36'(b);
		fork
			read_burst(rows[1].a);
			begin
				rdReady = 1'b0;
				repeat (24) @(negedge clock);
				rdReady = 1'b1;
			end
		join
		termDriven = 1'b0;
		do_reset();
		check("termFloat", termRangeHigh, 36'h1);
		wrap_up();
	end
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule
bind qsp_port qsp_port_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .MEM_AW(MEM_AW)) u_qsp_port_chk (
	.clock(clock), .rst(rst), .inStrobe(inStrobe), .inStrobeN(inStrobeN), .write_port_sel_n(write_port_sel_n),
	.read_port_sel_n(read_port_sel_n), .addr(addr), .wrData(wrData), .byte_lane_sel_n(byte_lane_sel_n),
	.rdData(rdData), .rdDataOe(rdDataOe), .echo_strobe(echo_strobe), .echo_strobeN(echo_strobeN),
	.read_valid_flag(read_valid_flag), .rdReady(rdReady), .termination_range_sel(termination_range_sel),
	.termRangeSelDriven(termRangeSelDriven), .termRangeHigh(termRangeHigh));
